// ==== logic/lss_aligner.sv ====
// Multiframe clock aligner with alignment-edge phase check, rotation and status registers.
`timescale 1ns/1ps
`default_nettype none

module lss_aligner (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // External alignment pulse pin.
  input wire logic sysref_i,
  // Register access port from the serial interface.
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  output logic [7:0] reg_rdata_o,
  // Multiframe clock, busy and interrupt outputs.
  output logic lmfc_o,
  output logic align_in_progress_o,
  output logic irq_o
);

  // Register storage.
  logic [3:0] irq_enable_reg;
  logic [3:0] irq_status_reg;
  logic [2:0] phase_tolerance_field_reg;
  logic [7:0] snap_err_reg;
  logic [1:0] snap_flags_reg;
  logic align_enable_reg;
  logic align_arm_reg;
  logic [3:0] align_mode_select_reg;
  logic align_locked_reg;
  logic align_window_exceeded_reg;
  logic align_rotated_sticky_reg;
  logic align_edge_seen_sticky_reg;
  logic [7:0] live_phase_error_low_reg;
  logic [1:0] live_phase_error_reg;
  logic [2:0] global_subclass_reg;
  logic [2:0] link_subclass_reg;
  logic [7:0] rdata_reg;

  // Alignment datapath registers.
  logic sysref_meta_reg;
  logic sysref_sync_reg;
  logic sysref_prev_reg;
  logic [3:0] lmfc_cnt_reg;
  logic [3:0] ref_cnt_reg;
  logic lmfc_pulse_reg;
  logic [2:0] hold_cnt_reg;
  lss_pkg::lss_state_t state_reg;
  lss_pkg::lss_state_t state_next;

  // Write strobes per register.
  wire wr_ctrl_w = reg_wr_i && (reg_addr_i == lss_pkg::CTRL_ADDR);
  wire wr_irq_en_w = reg_wr_i && (reg_addr_i == lss_pkg::IRQ_ENABLE_ADDR);
  wire wr_irq_stat_w = reg_wr_i && (reg_addr_i == lss_pkg::IRQ_STATUS_ADDR);
  wire wr_window_w = reg_wr_i && (reg_addr_i == lss_pkg::ERR_WINDOW_ADDR);
  wire wr_gsub_w = reg_wr_i && (reg_addr_i == lss_pkg::GLOBAL_SUBCLASS_ADDR);
  wire wr_lsub_w = reg_wr_i && (reg_addr_i == lss_pkg::LINK_SUBCLASS_ADDR);
  wire clr_sticky_w = wr_ctrl_w && reg_wdata_i[lss_pkg::CTRL_CLR_STICKY_BIT];
  wire arm_write_w = wr_ctrl_w && reg_wdata_i[lss_pkg::CTRL_ARM_BIT];

  // Alignment edge source: external pin in subclass one, internal divider otherwise.
  wire subclass_one_w = (global_subclass_reg == lss_pkg::SUBCLASS_ONE);
  wire ext_edge_w = sysref_sync_reg && !sysref_prev_reg;
  wire int_edge_w = (ref_cnt_reg == lss_pkg::LMFC_LAST);
  wire align_edge_w = subclass_one_w ? ext_edge_w : int_edge_w;

  // Mode decode.
  wire mode_cont_w = (align_mode_select_reg == lss_pkg::MODE_CONTINUOUS);
  wire mode_mon_w = (align_mode_select_reg == lss_pkg::MODE_SHOT_MONITOR);
  wire mode_shot_w = (align_mode_select_reg == lss_pkg::MODE_ONE_SHOT) || mode_mon_w;

  // Phase error: the counter should read zero on an edge; small values are late, large early.
  wire high_side_w = (lmfc_cnt_reg != 4'h0) && (lmfc_cnt_reg < lss_pkg::LMFC_HALF);
  wire low_side_w = (lmfc_cnt_reg >= lss_pkg::LMFC_HALF);
  wire [3:0] err_mag_w = low_side_w ? 4'(4'h0 - lmfc_cnt_reg) : lmfc_cnt_reg;
  // A zero field allows half a cycle, so any whole-cycle error is already outside it.
  wire exceed_w = (phase_tolerance_field_reg == 3'h0) ? (err_mag_w != 4'h0)
                  : (err_mag_w > {1'b0, phase_tolerance_field_reg});

  // Check and rotation decisions; edges in idle or rotate states are not checked.
  wire check_w = align_edge_w && ((state_reg == lss_pkg::LSS_WAIT) ||
                 (state_reg == lss_pkg::LSS_MONITOR));
  wire rotate_w = check_w && (state_reg == lss_pkg::LSS_WAIT) && exceed_w;
  wire hold_done_w = (hold_cnt_reg == 3'h0);

  // State after a finished check: continuous waits again, monitor watches, one shot stops.
  wire lss_pkg::lss_state_t after_w = mode_cont_w ? lss_pkg::LSS_WAIT
                                     : (mode_mon_w ? lss_pkg::LSS_MONITOR : lss_pkg::LSS_IDLE);

  // Interrupt events raised by each check.
  wire [3:0] irq_event_w = {check_w && !rotate_w && exceed_w, check_w, rotate_w,
                            check_w && (rotate_w || !exceed_w)};

  // Busy: waiting for an armed edge or rotating; a continuous wait is idle-ready.
  assign align_in_progress_o = ((state_reg == lss_pkg::LSS_WAIT) && !mode_cont_w) ||
                               (state_reg == lss_pkg::LSS_ROTATE);
  assign irq_o = |(irq_status_reg & irq_enable_reg);
  assign lmfc_o = lmfc_pulse_reg;
  assign reg_rdata_o = rdata_reg;

  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      lss_pkg::LSS_IDLE: begin
        if (align_enable_reg && (mode_cont_w || (mode_shot_w && align_arm_reg))) begin
          state_next = lss_pkg::LSS_WAIT;
        end
      end
      lss_pkg::LSS_WAIT: begin
        if (!align_enable_reg) begin
          state_next = lss_pkg::LSS_IDLE;
        end else if (rotate_w) begin
          state_next = lss_pkg::LSS_ROTATE;
        end else if (check_w) begin
          state_next = after_w;
        end
      end
      lss_pkg::LSS_ROTATE: begin
        if (hold_done_w) begin
          state_next = align_enable_reg ? after_w : lss_pkg::LSS_IDLE;
        end
      end
      lss_pkg::LSS_MONITOR: begin
        if (!align_enable_reg) begin
          state_next = lss_pkg::LSS_IDLE;
        end else if (align_arm_reg) begin
          state_next = lss_pkg::LSS_WAIT;
        end
      end
    endcase
  end

  // Pin synchroniser; the second and third flops feed the edge detector.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sysref_meta_reg <= 1'b0;
      sysref_sync_reg <= 1'b0;
      sysref_prev_reg <= 1'b0;
    end else begin
      sysref_meta_reg <= sysref_i;
      sysref_sync_reg <= sysref_meta_reg;
      sysref_prev_reg <= sysref_sync_reg;
    end
  end

  // Multiframe counter; a rotation loads one so the next wrap lands a period after the edge.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      lmfc_cnt_reg <= 4'h0;
      ref_cnt_reg <= 4'h0;
      lmfc_pulse_reg <= 1'b0;
    end else begin
      ref_cnt_reg <= 4'(ref_cnt_reg + 4'h1);
      lmfc_cnt_reg <= rotate_w ? 4'h1 : 4'(lmfc_cnt_reg + 4'h1);
      lmfc_pulse_reg <= rotate_w || (lmfc_cnt_reg == lss_pkg::LMFC_LAST);
    end
  end

  // Sequencer state and rotation hold-off timer.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= lss_pkg::LSS_IDLE;
      hold_cnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= rotate_w ? lss_pkg::ROTATE_HOLD_CYCLES
                      : (hold_done_w ? 3'h0 : 3'(hold_cnt_reg - 3'h1));
    end
  end

  // Control and configuration registers; a software arm wins over the self-clear.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      align_enable_reg <= 1'b0;
      align_arm_reg <= 1'b0;
      align_mode_select_reg <= lss_pkg::REG_RESET[3:0];
      phase_tolerance_field_reg <= lss_pkg::REG_RESET[2:0];
      irq_enable_reg <= lss_pkg::REG_RESET[3:0];
      global_subclass_reg <= lss_pkg::REG_RESET[2:0];
      link_subclass_reg <= lss_pkg::REG_RESET[2:0];
    end else begin
      if (wr_ctrl_w) begin
        align_enable_reg <= reg_wdata_i[lss_pkg::CTRL_ENABLE_BIT];
        align_mode_select_reg <= reg_wdata_i[3:0];
      end
      if (arm_write_w) begin
        align_arm_reg <= 1'b1;
      end else if (align_edge_w && align_enable_reg) begin
        align_arm_reg <= 1'b0;
      end
      if (wr_window_w) begin
        phase_tolerance_field_reg <= reg_wdata_i[2:0];
      end
      if (wr_irq_en_w) begin
        irq_enable_reg <= reg_wdata_i[3:0];
      end
      if (wr_gsub_w) begin
        global_subclass_reg <= reg_wdata_i[2:0];
      end
      if (wr_lsub_w) begin
        link_subclass_reg <= reg_wdata_i[7:5];
      end
    end
  end

  // Phase check results, live error, snapshots and sticky bits.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      align_locked_reg <= 1'b0;
      align_window_exceeded_reg <= 1'b0;
      align_rotated_sticky_reg <= 1'b0;
      align_edge_seen_sticky_reg <= 1'b0;
      live_phase_error_low_reg <= lss_pkg::REG_RESET;
      live_phase_error_reg <= 2'b00;
      snap_err_reg <= lss_pkg::REG_RESET;
      snap_flags_reg <= 2'b00;
    end else begin
      if (check_w) begin
        align_locked_reg <= rotate_w || !exceed_w;
        align_window_exceeded_reg <= exceed_w && !rotate_w;
      end
      if (rotate_w) begin
        live_phase_error_low_reg <= 8'h00;
        live_phase_error_reg <= 2'b00;
        snap_err_reg <= live_phase_error_low_reg;
        snap_flags_reg <= live_phase_error_reg;
      end else if (check_w) begin
        live_phase_error_low_reg <= {4'h0, err_mag_w};
        live_phase_error_reg <= {exceed_w && high_side_w, exceed_w && low_side_w};
      end
      // A set in the same cycle as the clear is kept, so no event is lost.
      if (rotate_w) begin
        align_rotated_sticky_reg <= 1'b1;
      end else if (clr_sticky_w) begin
        align_rotated_sticky_reg <= 1'b0;
      end
      if (check_w) begin
        align_edge_seen_sticky_reg <= 1'b1;
      end else if (clr_sticky_w) begin
        align_edge_seen_sticky_reg <= 1'b0;
      end
    end
  end

  // Interrupt status: write one to clear, a new event in the same cycle stays set.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_status_reg <= lss_pkg::REG_RESET[3:0];
    end else begin
      irq_status_reg <= (irq_status_reg & ~(wr_irq_stat_w ? reg_wdata_i[3:0] : 4'h0))
                        | irq_event_w;
    end
  end

  // Read data is registered one cycle after the address; unmapped addresses read zero.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_reg <= lss_pkg::REG_RESET;
    end else begin
      unique case (reg_addr_i)
        lss_pkg::IRQ_ENABLE_ADDR: rdata_reg <= {4'h0, irq_enable_reg};
        lss_pkg::IRQ_STATUS_ADDR: rdata_reg <= {4'h0, irq_status_reg};
        lss_pkg::ERR_WINDOW_ADDR: rdata_reg <= {5'h00, phase_tolerance_field_reg};
        lss_pkg::SNAP_ERR_ADDR: rdata_reg <= snap_err_reg;
        lss_pkg::SNAP_FLAGS_ADDR: rdata_reg <= {snap_flags_reg, 6'h00};
        lss_pkg::CTRL_ADDR: rdata_reg <= {align_enable_reg, align_arm_reg, 2'b00, align_mode_select_reg};
        lss_pkg::STATUS_ADDR: rdata_reg <= {align_in_progress_o, 3'h0, align_locked_reg,
                                            align_rotated_sticky_reg, align_window_exceeded_reg,
                                            align_edge_seen_sticky_reg};
        lss_pkg::LIVE_ERR_ADDR: rdata_reg <= live_phase_error_low_reg;
        lss_pkg::LIVE_FLAGS_ADDR: rdata_reg <= {live_phase_error_reg, 6'h00};
        lss_pkg::GLOBAL_SUBCLASS_ADDR: rdata_reg <= {5'h00, global_subclass_reg};
        lss_pkg::LINK_SUBCLASS_ADDR: rdata_reg <= {link_subclass_reg, 5'h00};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== shared/lss_pkg.sv ====
// Package with register map, field positions, codes and timing counts for the multiframe clock aligner.
package lss_pkg;
  // Register offsets.
  localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h021;
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h025;
  localparam logic [11:0] ERR_WINDOW_ADDR = 12'h034;
  localparam logic [11:0] SNAP_ERR_ADDR = 12'h038;
  localparam logic [11:0] SNAP_FLAGS_ADDR = 12'h039;
  localparam logic [11:0] CTRL_ADDR = 12'h03a;
  localparam logic [11:0] STATUS_ADDR = 12'h03b;
  localparam logic [11:0] LIVE_ERR_ADDR = 12'h03c;
  localparam logic [11:0] LIVE_FLAGS_ADDR = 12'h03d;
  localparam logic [11:0] GLOBAL_SUBCLASS_ADDR = 12'h301;
  localparam logic [11:0] LINK_SUBCLASS_ADDR = 12'h458;

  // Control register fields.
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_ARM_BIT = 6;
  localparam int CTRL_CLR_STICKY_BIT = 5;

  // Status register fields.
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_ROTATE_BIT = 2;
  localparam int STAT_WLIM_BIT = 1;
  localparam int STAT_TRIP_BIT = 0;

  // Live error flag fields (low side and high side).
  localparam int FLAG_LOW_BIT = 6;
  localparam int FLAG_HIGH_BIT = 7;

  // Interrupt event bit positions in enable and status registers.
  localparam int IRQ_LOCK_BIT = 0;
  localparam int IRQ_ROTATE_BIT = 1;
  localparam int IRQ_TRIP_BIT = 2;
  localparam int IRQ_WLIM_BIT = 3;

  // Mode codes.
  localparam logic [3:0] MODE_ONE_SHOT = 4'h1;
  localparam logic [3:0] MODE_CONTINUOUS = 4'h2;
  localparam logic [3:0] MODE_SHOT_MONITOR = 4'h9;

  // Subclass code that selects the external alignment edge.
  localparam logic [2:0] SUBCLASS_ONE = 3'h1;

  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Multiframe length in device clock cycles and the rotation hold-off.
  localparam int LMFC_W = 4;
  localparam logic [LMFC_W-1:0] LMFC_LAST = 4'hf;
  localparam logic [LMFC_W-1:0] LMFC_HALF = 4'h8;
  localparam logic [2:0] ROTATE_HOLD_CYCLES = 3'h4;

  // Aligner states.
  typedef enum logic [1:0] {
    LSS_IDLE = 2'b00,
    LSS_WAIT = 2'b01,
    LSS_ROTATE = 2'b10,
    LSS_MONITOR = 2'b11
  } lss_state_t;
endpackage

// ==== tb/lss_aligner_asserts.sv ====
// Port checker for the multiframe clock aligner, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module lss_aligner_chk (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Alignment pin and register port.
  input wire logic sysref_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_rdata_o,
  // Frame clock, busy and interrupt.
  input wire logic lmfc_o,
  input wire logic align_in_progress_o,
  input wire logic irq_o
);
  logic [7:0] gap_reg;
  logic [3:0] ien_reg;
  logic [2:0] link_reg;
  wire ien_wr = reg_wr_i && (reg_addr_i == lss_pkg::IRQ_ENABLE_ADDR);
  wire link_wr = reg_wr_i && (reg_addr_i == lss_pkg::LINK_SUBCLASS_ADDR);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  // Write shadows and the gap since the last frame pulse; a rotation only shortens a gap.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gap_reg <= 8'h00;
      ien_reg <= 4'h0;
      link_reg <= 3'h0;
    end else begin
      gap_reg <= lmfc_o ? 8'h00 : gap_reg + 8'h01;
      if (ien_wr) ien_reg <= reg_wdata_i[3:0];
      if (link_wr) link_reg <= reg_wdata_i[7:5];
    end
  end
  AST_RST_QUIET: assert property ($fell(sys_rst_i) |->
    reg_rdata_o == 8'h00 && !irq_o && !align_in_progress_o)
    else $error("outputs not quiet after reset");
  AST_BUSY_IN_STATUS: assert property (reg_addr_i == lss_pkg::STATUS_ADDR |=>
    reg_rdata_o[7] == $past(align_in_progress_o))
    else $error("status busy bit differs from busy output");
  AST_CLR_STICKY_READS_ZERO: assert property (reg_addr_i == lss_pkg::CTRL_ADDR |=> !reg_rdata_o[5])
    else $error("clear sticky bit read back as one");
  AST_IRQ_OFF_WHEN_DISABLED: assert property (ien_wr && reg_wdata_i[3:0] == 4'h0 |=> !irq_o)
    else $error("interrupt stays high with all events disabled");
  AST_IRQ_NEEDS_ENABLE: assert property (irq_o |-> ien_reg != 4'h0)
    else $error("interrupt high with no event enabled");
  AST_IEN_READBACK: assert property (reg_addr_i == lss_pkg::IRQ_ENABLE_ADDR && !reg_wr_i |=>
    reg_rdata_o[3:0] == ien_reg)
    else $error("interrupt enable readback wrong");
  AST_LINK_READBACK: assert property (reg_addr_i == lss_pkg::LINK_SUBCLASS_ADDR && !reg_wr_i |=>
    reg_rdata_o[7:5] == link_reg)
    else $error("link subclass readback wrong");
  AST_FRAME_PERIOD: assert property (gap_reg <= 8'd16)
    else $error("frame pulse missing for more than one period");
endmodule
bind lss_aligner lss_aligner_chk CHK (.clock_i, .sys_rst_i, .sysref_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rdata_o, .lmfc_o, .align_in_progress_o, .irq_o);
`default_nettype wire

// ==== tb/lss_sysref_src.sv ====
// Alignment pulse source standing in for the system clock generator.
`timescale 1ns/1ps
`default_nettype none
module lss_sysref_src #(parameter int PULSE_CYC = 2) (
  // Clock and trigger from the bench.
  input wire logic clock_i,
  input wire logic go_i,
  // Alignment pin, idle low between pulses.
  output logic sysref_o
);
  int cnt = 0;
  // Each trigger gives one active-high pulse; repeated triggers form a gapped periodic waveform.
  always @(posedge clock_i) begin
    if (go_i) cnt <= PULSE_CYC;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign sysref_o = (cnt > 0);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the multiframe clock aligner.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic go = 1'b0;
  logic sysref, lmfc, busy, irq;
  logic [7:0] rdata;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0, k;
  lss_aligner DUT (.clock_i, .sys_rst_i, .sysref_i(sysref), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_en), .reg_rdata_o(rdata), .lmfc_o(lmfc), .align_in_progress_o(busy), .irq_o(irq));
  lss_sysref_src SRC (.clock_i, .go_i(go), .sysref_o(sysref));
  // 20 MHz clock and a cycle count for placing pulses on the frame grid.
  initial forever #25 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 1;
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Register write, held for exactly one taking edge.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock_i);
    wr_en <= 1'b0;
  endtask
  // Read data is registered, so it is sampled one edge after the address.
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock_i);
    addr <= a;
    @(posedge clock_i);
    #1 chk($sformatf("reg %h", a), rdata & m, e);
  endtask
  // Pulse d cycles off the grid; the spacing is a whole number of frames so d is the phase error.
  task automatic pulse(input int d);
    k++;
    while (cyc < t0 + 48 * k + d) @(posedge clock_i);
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (16) @(posedge clock_i);
  endtask
  task automatic t_reset();
    logic [11:0] a[12] = '{12'h021, 12'h025, 12'h034, 12'h038, 12'h039, 12'h03a, 12'h03b, 12'h03c,
      12'h03d, 12'h301, 12'h458, 12'h100};
    foreach (a[i]) rd_chk(a[i], 8'hff, 8'h00);
    $display("test reset finished");
  endtask
  task automatic t_access();
    logic [11:0] a[6] = '{12'h034, 12'h038, 12'h021, 12'h458, 12'h301, 12'h03a};
    logic [7:0] d[6] = '{8'h05, 8'hff, 8'h0f, 8'h20, 8'h01, 8'h20};
    logic [7:0] e[6] = '{8'h05, 8'h00, 8'h0f, 8'h20, 8'h01, 8'h00};
    foreach (a[i]) begin
      wr(a[i], d[i]);
      rd_chk(a[i], 8'hff, e[i]);
    end
    $display("test access finished");
  endtask
  task automatic t_one_shot();
    wr(12'h034, 8'h00);
    wr(12'h03a, 8'h81);
    wr(12'h03a, 8'hc1);
    repeat (2) @(posedge clock_i);
    #1 chk("busy", {7'h00, busy}, 8'h01);
    while (lmfc !== 1'b1) @(posedge clock_i);
    t0 = cyc + 6;
    k = -1;
    pulse(0);
    rd_chk(12'h03b, 8'hff, 8'h0d);
    rd_chk(12'h03a, 8'hff, 8'h81);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(12'h03a, 8'ha1);
    pulse(3);
    rd_chk(12'h03b, 8'h05, 8'h00);
    $display("test one_shot finished");
  endtask
  task automatic t_monitor();
    wr(12'h034, 8'h01);
    wr(12'h03a, 8'h89);
    wr(12'h03a, 8'hc9);
    pulse(0);
    rd_chk(12'h03c, 8'hff, 8'h00);
    pulse(2);
    rd_chk(12'h03c, 8'hff, 8'h02);
    rd_chk(12'h03d, 8'hc0, 8'h80);
    rd_chk(12'h03b, 8'h0f, 8'h03);
    pulse(-3);
    rd_chk(12'h03d, 8'hc0, 8'h40);
    wr(12'h03a, 8'hc9);
    pulse(-3);
    t0 = t0 - 3;
    rd_chk(12'h038, 8'hff, 8'h03);
    rd_chk(12'h039, 8'hc0, 8'h40);
    rd_chk(12'h03c, 8'hff, 8'h00);
    $display("test monitor finished");
  endtask
  task automatic t_continuous();
    wr(12'h034, 8'h02);
    wr(12'h03a, 8'he2);
    pulse(2);
    rd_chk(12'h03b, 8'h07, 8'h01);
    rd_chk(12'h03a, 8'hff, 8'h82);
    pulse(3);
    rd_chk(12'h03b, 8'h07, 8'h05);
    $display("test continuous finished");
  endtask
  task automatic t_subclass0();
    wr(12'h03a, 8'ha1);
    wr(12'h301, 8'h00);
    wr(12'h03a, 8'hc1);
    repeat (40) @(posedge clock_i);
    rd_chk(12'h03a, 8'hff, 8'h81);
    rd_chk(12'h03b, 8'h81, 8'h01);
    rd_chk(12'h025, 8'h04, 8'h04);
    wr(12'h025, 8'h0f);
    rd_chk(12'h025, 8'h0f, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(12'h021, 8'h00);
    $display("test subclass0 finished");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clock_i);
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_access();
    t_one_shot();
    t_monitor();
    t_continuous();
    t_subclass0();
    finish_test();
  end
endmodule
`default_nettype wire
